// ### spc_cfg.svh
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SPC_ADDR_CTRL 12'h000
`define SPC_ADDR_OUT 12'h004
`define SPC_ADDR_DIR 12'h008
`define SPC_ADDR_PULL 12'h00C
`define SPC_ADDR_EIEN 12'h010
`define SPC_ADDR_GPIO 12'h014
`define SPC_ADDR_IN 12'h018
`define SPC_ADDR_STAT 12'h01C
`define SPC_ADDR_MASK 12'h020
`define SPC_ADDR_MODE 12'h024
// ctrl fields
`define SPC_CTRL_SEL 0
`define SPC_CTRL_MODE_LSB 1
`define SPC_CTRL_MODE_MSB 2
`define SPC_CTRL_TWWAKE 3
// status bits and pin reset level
`define SPC_ST_EDGE 0
`define SPC_ST_WAKE 1
`define SPC_IRQ_BITS 2
`define SPC_PIN_RST 1'b0
`endif

// ### spc_pkg.sv
package spc_pkg;
    typedef enum logic [1:0] {
        SPC_NORMAL = 2'b00,
        SPC_SLEEP = 2'b01,
        SPC_STOP = 2'b10,
        SPC_WATCH = 2'b11
    } spc_mode_type;
endpackage : spc_pkg

// ### spc_pin_cell.sv
`timescale 1ns/10ps
`include "spc_cfg.svh"
module spc_pin_cell
    import spc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_reset,
    input wire logic standby,
    input wire logic level_sel,
    input wire logic is_gpio,
    input wire logic reset_enabled,
    input wire logic drv_val,
    input wire logic drv_en,
    input wire logic pull_cfg,
    input wire logic pin_in,
    output logic pin_out_q,
    output logic pin_oe_q,
    output logic pin_pu_q,
    output logic gate_q
);
    logic gated;
    assign gated = standby && is_gpio;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_out_q <= `SPC_PIN_RST;
            pin_oe_q <= `SPC_PIN_RST;
        end else if (in_reset) begin
            pin_oe_q <= 1'b0;
        end else if (gated) begin
            // hold value; float only when select bit set
            if (level_sel) begin
                pin_oe_q <= 1'b0;
            end
        end else begin
            pin_out_q <= drv_val;
            pin_oe_q <= drv_en;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_pu_q <= 1'b0;
        end else begin
            pin_pu_q <= pull_cfg && !in_reset;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gate_q <= 1'b0;
        end else if (in_reset) begin
            gate_q <= reset_enabled ? pin_in : 1'b0;
        end else if (gated) begin
            gate_q <= 1'b0;
        end else begin
            gate_q <= pin_in;
        end
    end
endmodule : spc_pin_cell

// ### spc_edge_det.sv
`timescale 1ns/10ps
module spc_edge_det #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] sig_in,
    input wire logic [WIDTH-1:0] enable,
    output logic any_edge
);
    logic [WIDTH-1:0] prev_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_q <= '0;
        end else begin
            prev_q <= sig_in;
        end
    end
    assign any_edge = |((prev_q ^ sig_in) & enable);
endmodule : spc_edge_det

// ### spc_standby_pins.sv
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "spc_cfg.svh"
module spc_standby_pins
    import spc_pkg::*;
#(
    parameter int NPINS = 8,
    parameter int NTW = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sys_reset_hold,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPINS-1:0] periph_out,
    input wire logic [NPINS-1:0] periph_oe,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    output logic [NPINS-1:0] pin_pullup,
    output logic [NPINS-1:0] port_in,
    output logic [NPINS-1:0] ext_int_in,
    output logic wakeup,
    output logic irq
);
    initial begin
        if (NPINS < 1 || NPINS > 32 || NTW < 1 || NTW > NPINS) begin
            $error("spc_standby_pins: bad pin counts");
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic level_sel_q;
    logic tw_wake_en_q;
    spc_mode_type mode_q;
    logic [NPINS-1:0] out_q, dir_q, pull_q, eien_q, gpio_q, reset_en_q;
    logic [`SPC_IRQ_BITS-1:0] stat_q, mask_q;
    logic [31:0] rd_d;
    logic wr, rd, standby, in_reset, bus_ok;
    logic edge_evt, wake_evt, tw_edge;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign standby = (mode_q == SPC_STOP) || (mode_q == SPC_WATCH);
    assign in_reset = sys_reset_hold;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            level_sel_q <= 1'b0;
            tw_wake_en_q <= 1'b0;
            mode_q <= SPC_NORMAL;
            out_q <= '0;
            dir_q <= '0;
            pull_q <= '0;
            eien_q <= '0;
            gpio_q <= '1;
            mask_q <= '0;
        end else if (wr) begin
            case (paddr)
                `SPC_ADDR_CTRL: begin
                    level_sel_q <= pwdata[`SPC_CTRL_SEL];
                    mode_q <= spc_mode_type'(pwdata[`SPC_CTRL_MODE_MSB:`SPC_CTRL_MODE_LSB]);
                    tw_wake_en_q <= pwdata[`SPC_CTRL_TWWAKE];
                end
                `SPC_ADDR_OUT: out_q <= pwdata[NPINS-1:0];
                `SPC_ADDR_DIR: dir_q <= pwdata[NPINS-1:0];
                `SPC_ADDR_PULL: pull_q <= pwdata[NPINS-1:0];
                `SPC_ADDR_EIEN: eien_q <= pwdata[NPINS-1:0];
                `SPC_ADDR_GPIO: gpio_q <= pwdata[NPINS-1:0];
                `SPC_ADDR_MASK: mask_q <= pwdata[`SPC_IRQ_BITS-1:0];
                default: begin
                end
            endcase
        end else if (wake_evt && standby) begin
            mode_q <= SPC_NORMAL; // wake returns to normal operation
        end
    end

    // which pins keep gate enabled during reset: all by default
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reset_en_q <= '1;
        end else begin
            reset_en_q <= reset_en_q;
        end
    end

    // ----------------------------------------------------------------
    // pin cells
    // ----------------------------------------------------------------
    logic [NPINS-1:0] gate_w, pout_w, poe_w, pu_w;
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            spc_pin_cell u_cell (
                .sys_clk(sys_clk),
                .rst(rst),
                .in_reset(in_reset),
                .standby(standby),
                .level_sel(level_sel_q),
                .is_gpio(gpio_q[gi]),
                .reset_enabled(reset_en_q[gi]),
                .drv_val(gpio_q[gi] ? out_q[gi] : periph_out[gi]),
                .drv_en(gpio_q[gi] ? dir_q[gi] : periph_oe[gi]),
                .pull_cfg(pull_q[gi]),
                .pin_in(pin_in[gi]),
                .pin_out_q(pout_w[gi]),
                .pin_oe_q(poe_w[gi]),
                .pin_pu_q(pu_w[gi]),
                .gate_q(gate_w[gi])
            );
        end
    endgenerate

    assign pin_out = pout_w;
    assign pin_oe = poe_w;
    assign pin_pullup = pu_w;
    assign port_in = gate_w;

    // interrupt path bypasses the blocked gate for enabled pins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ext_int_in <= '0;
        end else begin
            ext_int_in <= pin_in & eien_q;
        end
    end

    spc_edge_det #(.WIDTH(NPINS)) u_ext (
        .sys_clk(sys_clk),
        .rst(rst),
        .sig_in(ext_int_in),
        .enable(eien_q),
        .any_edge(edge_evt)
    );

    // two-wire bus pins occupy the lowest NTW pins
    spc_edge_det #(.WIDTH(NTW)) u_tw (
        .sys_clk(sys_clk),
        .rst(rst),
        .sig_in(pin_in[NTW-1:0]),
        .enable({NTW{tw_wake_en_q}}),
        .any_edge(tw_edge)
    );

    assign wake_evt = (tw_edge || edge_evt) && standby;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wakeup <= 1'b0;
        end else begin
            wakeup <= wake_evt;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, write one to clear, set wins
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~((wr && paddr == `SPC_ADDR_STAT)
                ? pwdata[`SPC_IRQ_BITS-1:0] : '0))
                | {wake_evt, edge_evt};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // apb read and answer
    // ----------------------------------------------------------------
    always_comb begin
        rd_d = '0;
        bus_ok = 1'b1;
        case (paddr)
            `SPC_ADDR_CTRL: rd_d[3:0] = {tw_wake_en_q, mode_q, level_sel_q};
            `SPC_ADDR_OUT: rd_d[NPINS-1:0] = out_q;
            `SPC_ADDR_DIR: rd_d[NPINS-1:0] = dir_q;
            `SPC_ADDR_PULL: rd_d[NPINS-1:0] = pull_q;
            `SPC_ADDR_EIEN: rd_d[NPINS-1:0] = eien_q;
            `SPC_ADDR_GPIO: rd_d[NPINS-1:0] = gpio_q;
            `SPC_ADDR_IN: rd_d[NPINS-1:0] = gate_w;
            `SPC_ADDR_STAT: rd_d[`SPC_IRQ_BITS-1:0] = stat_q;
            `SPC_ADDR_MASK: rd_d[`SPC_IRQ_BITS-1:0] = mask_q;
            default: bus_ok = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !bus_ok;
            if (rd) begin
                prdata <= rd_d;
            end
        end
    end
endmodule : spc_standby_pins

// ### spc_standby_pins_assertions.sv
`timescale 1ns/10ps
module spc_standby_pins_assertions #(
    parameter int NPINS = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sys_reset_hold,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NPINS-1:0] pin_in,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] port_in,
    input wire logic [NPINS-1:0] ext_int_in,
    input wire logic wakeup,
    input wire logic irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----
    // bus and pin relations
    // ----
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (psel && penable && paddr == 12'h024 |-> pslverr)
        else $error("unmapped access not refused");
    a_rdata_hold: assert property (!(psel && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    a_reset_float: assert property (sys_reset_hold [*2] |-> pin_oe == '0)
        else $error("pin driven during reset");
    // gated input may only show levels the pin really had
    a_gate_subset: assert property ((port_in & ~$past(pin_in)) == '0)
        else $error("gated input shows absent level");
    a_extint_subset: assert property ((ext_int_in & ~$past(pin_in)) == '0)
        else $error("interrupt input shows absent level");
    a_wake_pulse: assert property (wakeup |=> !wakeup)
        else $error("wakeup longer than one cycle");
    c_wake: cover property (wakeup);
    c_irq: cover property (irq);
    c_err: cover property (pslverr);
endmodule : spc_standby_pins_assertions
bind spc_standby_pins spc_standby_pins_assertions #(.NPINS(NPINS)) u_chk (.*);

// ### spc_board.sv
`timescale 1ns/10ps
module spc_board (
    input wire logic sys_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    logic [7:0] noise_q = 8'h00;
    // an undriven, unpulled pin wanders so no stale level passes for data
    always_ff @(posedge sys_clk) noise_q <= ~noise_q;
    always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pullup | noise_q));
endmodule : spc_board

// ### tb.sv
`timescale 1ns/10ps
module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic sys_reset_hold = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, wakeup, irq;
    logic [7:0] periph_out = 8'hA5;
    logic [7:0] periph_oe = 8'h3C;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_en = 8'hFF;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, port_in, ext_int_in, o, d, p;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int wakes = 0;
    int seed = 32'h596DFCD3;
    spc_standby_pins u_dut (.*);
    spc_board u_board (.*);
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (wakeup === 1'b1) wakes++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    // ----
    // tasks
    // ----
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, pready, 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // second idle edge lets registered outputs settle before checks
        @(posedge sys_clk);
        @(posedge sys_clk);
    endtask : apb
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    function automatic logic [7:0] exp_in(input logic [7:0] dr, ov, ev);
        return (dr & ov) | (~dr & ev);
    endfunction : exp_in
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // ----
    // sequence
    // ----
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd[7:0], 8'hFF);
        apb(1'b0, 12'h024, 32'h0);
        chk({7'h0, err}, 8'h01);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            o = 8'($random(seed));
            d = 8'($random(seed));
            p = 8'($random(seed));
            ext_val <= 8'($random(seed));
            ext_en <= ~d;
            apb(1'b1, 12'h004, {24'h0, o});
            apb(1'b1, 12'h008, {24'h0, d});
            apb(1'b1, 12'h00C, {24'h0, p});
            apb(1'b1, 12'h000, {30'h0, i[0], 1'b0});
            chk(pin_oe, d);
            chk(pin_out & d, o & d);
            chk(port_in, exp_in(d, o, ext_val));
        end
        $display("test normal and sleep done");
        for (int m = 2; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
                apb(1'b1, 12'h000, 32'(m * 2 + s));
                // a new output value must not leak out while held
                apb(1'b1, 12'h004, {24'h0, ~o});
                chk(port_in, 8'h00);
                chk(pin_oe, s ? 8'h00 : d);
                chk(pin_out & pin_oe, s ? 8'h00 : o & d);
                if (s) chk(pin_pullup, p);
                apb(1'b1, 12'h000, 32'h0);
                apb(1'b1, 12'h004, {24'h0, o});
            end
        end
        $display("test standby done");
        apb(1'b1, 12'h014, 32'h0);
        chk(pin_oe, periph_oe);
        chk(pin_out & pin_oe, periph_out & periph_oe);
        apb(1'b1, 12'h014, 32'h000000FF);
        apb(1'b1, 12'h008, 32'h0);
        ext_en <= 8'hFF;
        ext_val <= 8'h00;
        apb(1'b1, 12'h010, 32'h000000FC);
        apb(1'b1, 12'h000, 32'h00000005);
        ext_val <= 8'hF0;
        repeat (3) @(posedge sys_clk);
        chk(ext_int_in, 8'hF0);
        apb(1'b0, 12'h01C, 32'h0);
        chk(rd[7:0] & 8'h01, 8'h01);
        chk({7'h0, irq}, 8'h00);
        apb(1'b1, 12'h020, 32'h00000003);
        chk({7'h0, irq}, 8'h01);
        apb(1'b1, 12'h01C, 32'h00000003);
        chk({7'h0, irq}, 8'h00);
        apb(1'b1, 12'h020, 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        $display("test interrupt done");
        wakes = 0;
        apb(1'b1, 12'h000, 32'h0000000D);
        ext_val <= 8'hF3;
        @(posedge sys_clk);
        ext_val <= 8'hF0;
        repeat (4) @(posedge sys_clk);
        chk({7'h0, wakes > 0}, 8'h01);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd[7:0] & 8'h06, 8'h00);
        apb(1'b0, 12'h01C, 32'h0);
        chk(rd[7:0] & 8'h02, 8'h02);
        $display("test wakeup done");
        apb(1'b1, 12'h008, 32'h000000FF);
        sys_reset_hold <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(pin_oe, 8'h00);
        sys_reset_hold <= 1'b0;
        $display("test reset hold done");
        test_done();
    end
endmodule : tb
